// ### design/gpio_de_pkg.sv
// Purpose: Shared constants and carrier types for the port D / port E I/O block.
// Assumes: Byte-wide CPU register port with address, read and write strobes.
// Notes: Offsets without a printed value are placed next to the printed ones.
package gpio_de_pkg;

    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam logic [15:0] ADDR_PORT_D_DATA = 16'h0003;
    localparam logic [15:0] ADDR_PORT_E_DATA = 16'h0008;
    localparam logic [15:0] ADDR_PORT_D_DIR = 16'h0007;
    localparam logic [15:0] ADDR_PORT_E_DIR = 16'h000C;
    localparam logic [15:0] ADDR_PORT_D_CTRL = 16'h000D;

    // ***************************************************************
    // Field layout and reset values
    // ***************************************************************
    localparam int PD_CTRL_SLOW6 = 0;
    localparam int PD_CTRL_SLOW7 = 1;
    localparam int PD_CTRL_PU6 = 2;
    localparam int PD_CTRL_PU7 = 3;
    localparam logic [7:0] PD_CTRL_WMASK = 8'h0F;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    localparam logic [1:0] PORT_E_MASK = 2'h3;
    localparam int PIN_TX = 6;
    localparam int PIN_RX = 7;
    localparam int PIN_T1C0 = 4;
    localparam int PIN_T1C1 = 5;

    // Bus carrier from the CPU side.
    typedef struct packed
    {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cpu_req_s;

    // Peripheral takeover request for one pin.
    typedef struct packed
    {
        logic take;
        logic out;
        logic oe;
    } pin_ovr_s;

    // Whole register state of the block.
    typedef struct packed
    {
        logic [7:0] pd_data;
        logic [7:0] pd_dir;
        logic [7:0] pd_ctrl;
        logic [1:0] pe_data;
        logic [1:0] pe_dir;
        logic [7:0] rdata;
    } regs_s;

endpackage

// ### design/gpio_pin_mux.sv
// Purpose: Per-pin driver selection between port logic and a peripheral.
// Assumes: Peripheral override request is already decoded.
// Notes: Purely combinational; open-drain only ever drives low.
`timescale 1ns/10ps
module gpio_pin_mux
(
    // Port logic side
    input wire logic latch_val,
    input wire logic dir_out,
    input wire logic open_drain,
    // Peripheral side
    input wire gpio_de_pkg::pin_ovr_s ovr,
    // Pin side
    output logic pin_out,
    output logic pin_oe
);
    logic val;
    logic en;

    always_comb
    begin
        val = ovr.take ? ovr.out : latch_val;
        en = ovr.take ? ovr.oe : dir_out;
        pin_out = val;
        // Open drain keeps the driver off while the value is high.
        // A peripheral that takes the pin also sets how it is driven.
        pin_oe = (open_drain && !ovr.take) ? (en & ~val) : en;
    end
endmodule

// ### design/gpio_readback.sv
// Purpose: Read-back selection of latch or pin level, one bit per pin.
// Assumes: Pin levels are synchronous to clk.
// Notes: Width is a parameter only so port D and port E share the code.
`timescale 1ns/10ps
module gpio_readback #(parameter int W = 8)
(
    // Inputs
    input wire logic [W-1:0] latch_val,
    input wire logic [W-1:0] dir_out,
    input wire logic [W-1:0] pin_level,
    // Result
    output logic [W-1:0] value
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            assign value[i] = dir_out[i] ? latch_val[i] : pin_level[i];
        end
    endgenerate
endmodule

// ### design/gpio_ports_d_e.sv
// Purpose: Port D (8 pins) and port E (2 pins) data, direction and control logic.
// Assumes: CPU register access by address with read and write strobes, read data
//          one cycle after the read strobe.
// Notes: Data latches are not reset; direction and control bits are.
//
// Summary of operation
// - Eight writable port D latches; reset leaves their contents alone.
// - Port D direction 1 drives the pin, 0 leaves it an input.
// - Reset clears all port D direction bits.
// - Port D read gives latch where output, pin level where input.
// - Latch writes always land, but input pins still read the pin.
// - Serial enable hands pins 6 and 7 to transmit and receive.
// - Timer 1 edge/level selects take pins 4 and 5 for channels.
// - An option bit routes I2C data and clock onto pins 6 and 7 unless serial enable holds them.
// - Slow-edge bit makes pin 6 or 7 open-drain while no peripheral owns it; direction untouched.
// - Pull-up bit for pins 6 and 7 acts regardless of direction.
// - Two writable port E latches, direction per bit.
// - Port E direction 1 drives the pin, 0 leaves it an input.
// - Reset clears both port E direction bits.
// - Port E read gives latch where output, pin level where input.
// - Timer 2 edge/level selects take port E pins for channels.
`timescale 1ns/10ps
module gpio_ports_d_e
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // CPU register port
    input wire gpio_de_pkg::cpu_req_s cpu,
    output logic [7:0] cpu_rdata,
    // Peripheral control
    input wire logic serial_iface_enable,
    input wire logic serial_tx,
    output logic serial_rx,
    input wire logic [1:0] timer1_edge_level_select_ch0,
    input wire logic [1:0] timer1_edge_level_select_ch1,
    input wire logic [1:0] timer1_out,
    input wire logic [1:0] timer1_oe,
    output logic [1:0] timer1_in,
    input wire logic [1:0] timer2_edge_level_select_ch0,
    input wire logic [1:0] timer2_edge_level_select_ch1,
    input wire logic [1:0] timer2_out,
    input wire logic [1:0] timer2_oe,
    output logic [1:0] timer2_in,
    input wire logic i2c_on_port_d,
    input wire logic i2c_sda_oe,
    input wire logic i2c_scl_oe,
    output logic i2c_sda_in,
    output logic i2c_scl_in,
    // Port D pins
    input wire logic [7:0] port_d_in,
    output logic [7:0] port_d_out,
    output logic [7:0] port_d_oe,
    output logic [1:0] port_d_pullup_enable,
    output logic [1:0] slow_edge_open_drain_enable,
    // Port E pins
    input wire logic [1:0] port_e_in,
    output logic [1:0] port_e_out,
    output logic [1:0] port_e_oe
);
    // ***************************************************************
    // State
    // ***************************************************************
    gpio_de_pkg::regs_s st_r;
    gpio_de_pkg::regs_s st_nxt;
    logic [7:0] pd_view;
    logic [1:0] pe_view;
    gpio_de_pkg::pin_ovr_s [7:0] pd_ovr;
    gpio_de_pkg::pin_ovr_s [1:0] pe_ovr;
    logic [7:0] pd_od;

    // ***************************************************************
    // Read-back multiplexers
    // ***************************************************************
    gpio_readback #(.W(8)) u_rb_d
    (
        .latch_val(st_r.pd_data),
        .dir_out(st_r.pd_dir),
        .pin_level(port_d_in),
        .value(pd_view)
    );

    gpio_readback #(.W(2)) u_rb_e
    (
        .latch_val(st_r.pe_data),
        .dir_out(st_r.pe_dir),
        .pin_level(port_e_in),
        .value(pe_view)
    );

    // ***************************************************************
    // Peripheral takeover
    // ***************************************************************
    // A timer channel owns its pin whenever its edge/level select is non-zero.
    // The serial interface wins over I2C when both claim pins 6 and 7.
    always_comb
    begin
        pd_ovr = '0;
        pe_ovr = '0;
        pd_ovr[gpio_de_pkg::PIN_T1C0] = '{|timer1_edge_level_select_ch0,
                                         timer1_out[0], timer1_oe[0]};
        pd_ovr[gpio_de_pkg::PIN_T1C1] = '{|timer1_edge_level_select_ch1,
                                         timer1_out[1], timer1_oe[1]};
        pe_ovr[0] = '{|timer2_edge_level_select_ch0, timer2_out[0], timer2_oe[0]};
        pe_ovr[1] = '{|timer2_edge_level_select_ch1, timer2_out[1], timer2_oe[1]};
        if (serial_iface_enable)
        begin
            pd_ovr[gpio_de_pkg::PIN_TX] = '{1'b1, serial_tx, 1'b1};
            pd_ovr[gpio_de_pkg::PIN_RX] = '{1'b1, 1'b1, 1'b0};
        end
        else if (i2c_on_port_d)
        begin
            // I2C lines only ever pull low.
            pd_ovr[gpio_de_pkg::PIN_TX] = '{1'b1, 1'b0, i2c_sda_oe};
            pd_ovr[gpio_de_pkg::PIN_RX] = '{1'b1, 1'b0, i2c_scl_oe};
        end
    end

    always_comb
    begin
        pd_od = '0;
        pd_od[gpio_de_pkg::PIN_TX] = st_r.pd_ctrl[gpio_de_pkg::PD_CTRL_SLOW6];
        pd_od[gpio_de_pkg::PIN_RX] = st_r.pd_ctrl[gpio_de_pkg::PD_CTRL_SLOW7];
    end

    // ***************************************************************
    // Pin drivers
    // ***************************************************************
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_pd
            gpio_pin_mux u_mux
            (
                .latch_val(st_r.pd_data[i]),
                .dir_out(st_r.pd_dir[i]),
                .open_drain(pd_od[i]),
                .ovr(pd_ovr[i]),
                .pin_out(port_d_out[i]),
                .pin_oe(port_d_oe[i])
            );
        end
        for (i = 0; i < 2; i++)
        begin : g_pe
            gpio_pin_mux u_mux
            (
                .latch_val(st_r.pe_data[i]),
                .dir_out(st_r.pe_dir[i]),
                .open_drain(1'b0),
                .ovr(pe_ovr[i]),
                .pin_out(port_e_out[i]),
                .pin_oe(port_e_oe[i])
            );
        end
    endgenerate

    // Pull-ups follow the control bits only, not the direction.
    assign port_d_pullup_enable = {st_r.pd_ctrl[gpio_de_pkg::PD_CTRL_PU7],
                                   st_r.pd_ctrl[gpio_de_pkg::PD_CTRL_PU6]};
    assign slow_edge_open_drain_enable = {st_r.pd_ctrl[gpio_de_pkg::PD_CTRL_SLOW7],
                                          st_r.pd_ctrl[gpio_de_pkg::PD_CTRL_SLOW6]};

    // Peripherals always see the raw pin level.
    assign serial_rx = port_d_in[gpio_de_pkg::PIN_RX];
    assign i2c_sda_in = port_d_in[gpio_de_pkg::PIN_TX];
    assign i2c_scl_in = port_d_in[gpio_de_pkg::PIN_RX];
    assign timer1_in = {port_d_in[gpio_de_pkg::PIN_T1C1], port_d_in[gpio_de_pkg::PIN_T1C0]};
    assign timer2_in = port_e_in;
    assign cpu_rdata = st_r.rdata;

    // ***************************************************************
    // Register access
    // ***************************************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rdata = gpio_de_pkg::READ_IDLE;
        if (cpu.wr)
        begin
            if (cpu.addr == gpio_de_pkg::ADDR_PORT_D_DATA)
            begin
                st_nxt.pd_data = cpu.wdata;
            end
            else if (cpu.addr == gpio_de_pkg::ADDR_PORT_E_DATA)
            begin
                st_nxt.pe_data = cpu.wdata[1:0];
            end
            else if (cpu.addr == gpio_de_pkg::ADDR_PORT_D_DIR)
            begin
                st_nxt.pd_dir = cpu.wdata;
            end
            else if (cpu.addr == gpio_de_pkg::ADDR_PORT_E_DIR)
            begin
                st_nxt.pe_dir = cpu.wdata[1:0] & gpio_de_pkg::PORT_E_MASK;
            end
            else if (cpu.addr == gpio_de_pkg::ADDR_PORT_D_CTRL)
            begin
                st_nxt.pd_ctrl = cpu.wdata & gpio_de_pkg::PD_CTRL_WMASK;
            end
        end
        if (cpu.rd)
        begin
            if (cpu.addr == gpio_de_pkg::ADDR_PORT_D_DATA)
            begin
                st_nxt.rdata = pd_view;
            end
            else if (cpu.addr == gpio_de_pkg::ADDR_PORT_E_DATA)
            begin
                st_nxt.rdata = {6'h00, pe_view};
            end
            else if (cpu.addr == gpio_de_pkg::ADDR_PORT_D_DIR)
            begin
                st_nxt.rdata = st_r.pd_dir;
            end
            else if (cpu.addr == gpio_de_pkg::ADDR_PORT_E_DIR)
            begin
                st_nxt.rdata = {6'h00, st_r.pe_dir};
            end
            else if (cpu.addr == gpio_de_pkg::ADDR_PORT_D_CTRL)
            begin
                st_nxt.rdata = st_r.pd_ctrl;
            end
        end
    end

    // ***************************************************************
    // State registers
    // ***************************************************************
    // Latches keep their value across reset, so the reset branch leaves the
    // latch fields out; they simply hold while rst_n is low. The cost is a
    // hold path on those flops, traded for a single state register.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r.pd_dir <= gpio_de_pkg::DIR_RESET;
            st_r.pe_dir <= gpio_de_pkg::DIR_RESET[1:0];
            st_r.pd_ctrl <= gpio_de_pkg::CTRL_RESET;
            st_r.rdata <= gpio_de_pkg::READ_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// ### sim/gpio_ports_d_e_chk.sv
// Purpose: Concurrent checks on the port D / port E block ports.
// Assumes: Pins D0 to D3 have no takeover, so their enables mirror direction.
// Notes: Attached to the block by the bind below.
`timescale 1ns/10ps
module gpio_ports_d_e_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // CPU port
    input wire gpio_de_pkg::cpu_req_s cpu,
    input wire logic [7:0] cpu_rdata,
    // Peripherals
    input wire logic serial_iface_enable,
    input wire logic serial_tx,
    input wire logic [1:0] timer1_edge_level_select_ch0,
    input wire logic [1:0] timer1_out,
    input wire logic [1:0] timer1_oe,
    input wire logic i2c_on_port_d,
    input wire logic i2c_sda_oe,
    // Pins
    input wire logic [7:0] port_d_in,
    input wire logic [7:0] port_d_out,
    input wire logic [7:0] port_d_oe,
    input wire logic [1:0] port_d_pullup_enable,
    input wire logic [1:0] slow_edge_open_drain_enable,
    input wire logic [1:0] port_e_oe
);
    logic [3:0] lvl_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // The read strobe cycle fixes what D0 to D3 must read back one cycle later.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lvl_r <= 4'h0;
        else
            lvl_r <= (port_d_oe[3:0] & port_d_out[3:0]) | (~port_d_oe[3:0] & port_d_in[3:0]);
    end
    sequence rd_d;
        cpu.rd && cpu.addr == gpio_de_pkg::ADDR_PORT_D_DATA;
    endsequence
    sequence wr_dir;
        cpu.wr && cpu.addr == gpio_de_pkg::ADDR_PORT_D_DIR;
    endsequence
    sequence wr_ctl;
        cpu.wr && cpu.addr == gpio_de_pkg::ADDR_PORT_D_CTRL;
    endsequence
    AST_RD_D: assert property (rd_d |=> cpu_rdata[3:0] == lvl_r)
        else $error("port D read-back wrong");
    AST_IDLE: assert property (!cpu.rd |=> cpu_rdata == 8'h00)
        else $error("read data not idle");
    AST_DIR_D: assert property (wr_dir |=> port_d_oe[3:0] == $past(cpu.wdata[3:0]))
        else $error("direction write not on enables");
    AST_CTRL: assert property (wr_ctl |=> {port_d_pullup_enable, slow_edge_open_drain_enable} == $past(cpu.wdata[3:0]))
        else $error("control bits wrong");
    AST_RST: assert property ($rose(rst_n) |-> port_d_oe[3:0] == 4'h0 && !port_e_oe[0])
        else $error("enables set after reset");
    AST_SER: assert property (serial_iface_enable |-> port_d_oe[6] && port_d_out[6] == serial_tx && !port_d_oe[7])
        else $error("serial takeover wrong");
    AST_I2C: assert property (i2c_on_port_d && !serial_iface_enable |-> port_d_oe[6] == i2c_sda_oe && !(port_d_oe[6] && port_d_out[6]))
        else $error("I2C takeover wrong");
    AST_T1: assert property (timer1_edge_level_select_ch0 != 2'h0 |-> port_d_oe[4] == timer1_oe[0] && (!timer1_oe[0] || port_d_out[4] == timer1_out[0]))
        else $error("timer takeover wrong");
    AST_OD: assert property (slow_edge_open_drain_enable[0] && !serial_iface_enable && !i2c_on_port_d && port_d_oe[6] |-> !port_d_out[6])
        else $error("open drain drives high");
endmodule
bind gpio_ports_d_e gpio_ports_d_e_chk chk (.clk(clk), .rst_n(rst_n), .cpu(cpu), .cpu_rdata(cpu_rdata),
    .serial_iface_enable(serial_iface_enable), .serial_tx(serial_tx), .i2c_on_port_d(i2c_on_port_d),
    .timer1_edge_level_select_ch0(timer1_edge_level_select_ch0), .timer1_out(timer1_out), .timer1_oe(timer1_oe),
    .i2c_sda_oe(i2c_sda_oe), .port_d_in(port_d_in), .port_d_out(port_d_out), .port_d_oe(port_d_oe),
    .port_d_pullup_enable(port_d_pullup_enable), .slow_edge_open_drain_enable(slow_edge_open_drain_enable),
    .port_e_oe(port_e_oe));

// ### sim/gpio_pins_model.sv
// Purpose: Pin level model for ports D and E.
// Assumes: An undriven pin sits at its pull-up or at the external level given.
// Notes: Open drain is seen as an enable that only comes with a low value.
`timescale 1ns/10ps
module gpio_pins_model
(
    // Block side
    input wire logic [7:0] d_out,
    input wire logic [7:0] d_oe,
    input wire logic [1:0] pu,
    input wire logic [1:0] e_out,
    input wire logic [1:0] e_oe,
    // Board side
    input wire logic [7:0] ext_d,
    input wire logic [1:0] ext_e,
    output logic [7:0] d_lvl,
    output logic [1:0] e_lvl
);
    assign d_lvl = (d_oe & d_out) | (~d_oe & ({pu, 6'h00} | ext_d));
    assign e_lvl = (e_oe & e_out) | (~e_oe & ext_e);
endmodule

// ### sim/tb_gpio_ports_d_e.sv
// Purpose: Self-checking bench for the port D / port E block.
// Assumes: One register access every second cycle.
// Notes: Pin levels come from the pin model.
`timescale 1ns/10ps
module tb_gpio_ports_d_e;
    logic clk, rst_n, ser_en, ser_tx, ser_rx, i2c_on, sda_oe, scl_oe, sda_in, scl_in;
    logic [1:0] t1s, t1o, t1e, t1i, t2s, t2o, t2e, t2i, pu, slow, pe_in, pe_out, pe_oe, ext_e;
    logic [7:0] rdata, pd_in, pd_out, pd_oe, ext_d;
    gpio_de_pkg::cpu_req_s cpu;
    int n_fail, n_tests, cyc;
    gpio_ports_d_e uut (.clk(clk), .rst_n(rst_n), .cpu(cpu), .cpu_rdata(rdata), .serial_iface_enable(ser_en),
        .serial_tx(ser_tx), .serial_rx(ser_rx), .timer1_edge_level_select_ch0(t1s),
        .timer1_edge_level_select_ch1(t1s), .timer1_out(t1o), .timer1_oe(t1e), .timer1_in(t1i),
        .timer2_edge_level_select_ch0(t2s), .timer2_edge_level_select_ch1(t2s), .timer2_out(t2o),
        .timer2_oe(t2e), .timer2_in(t2i), .i2c_on_port_d(i2c_on), .i2c_sda_oe(sda_oe), .i2c_scl_oe(scl_oe),
        .i2c_sda_in(sda_in), .i2c_scl_in(scl_in), .port_d_in(pd_in), .port_d_out(pd_out), .port_d_oe(pd_oe),
        .port_d_pullup_enable(pu), .slow_edge_open_drain_enable(slow), .port_e_in(pe_in),
        .port_e_out(pe_out), .port_e_oe(pe_oe));
    gpio_pins_model pins (.d_out(pd_out), .d_oe(pd_oe), .pu(pu), .e_out(pe_out), .e_oe(pe_oe), .ext_d(ext_d),
        .ext_e(ext_e), .d_lvl(pd_in), .e_lvl(pe_in));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic summarize();
        if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // A read compares the returned byte with d; a write sends d.
    task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
        cpu = '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        #1;
        cpu.wr = 1'b0;
        cpu.rd = 1'b0;
        if (!w)
            chk(rdata, d);
        @(posedge clk);
        #1;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        {rst_n, ser_en, ser_tx, i2c_on, sda_oe, scl_oe, t1s, t1o, t1e, t2s, t2o, t2e} = '0;
        cpu = '0;
        ext_d = 8'hA5;
        ext_e = 2'h2;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        acc(gpio_de_pkg::ADDR_PORT_D_DIR, 0, 8'h00);
        acc(gpio_de_pkg::ADDR_PORT_E_DIR, 0, 8'h00);
        acc(gpio_de_pkg::ADDR_PORT_D_CTRL, 0, 8'h00);
        chk({pe_oe, pd_oe[5:0]}, 8'h00);
        acc(gpio_de_pkg::ADDR_PORT_D_DATA, 1, 8'h3C);
        acc(gpio_de_pkg::ADDR_PORT_D_DATA, 0, 8'hA5);
        acc(gpio_de_pkg::ADDR_PORT_D_DIR, 1, 8'h0F);
        acc(gpio_de_pkg::ADDR_PORT_D_DATA, 0, 8'hAC);
        chk(pd_oe, 8'h0F);
        rst_n = 1'b0;
        @(posedge clk);
        #1 rst_n = 1'b1;
        acc(gpio_de_pkg::ADDR_PORT_D_DATA, 0, 8'hA5);
        acc(gpio_de_pkg::ADDR_PORT_D_DIR, 1, 8'hFF);
        acc(gpio_de_pkg::ADDR_PORT_D_DATA, 0, 8'h3C);
        acc(gpio_de_pkg::ADDR_PORT_D_CTRL, 1, 8'hFF);
        acc(gpio_de_pkg::ADDR_PORT_D_CTRL, 0, 8'h0F);
        chk(pd_oe, 8'hFF);
        acc(gpio_de_pkg::ADDR_PORT_D_DATA, 1, 8'hFF);
        chk(pd_oe, 8'h3F);
        acc(gpio_de_pkg::ADDR_PORT_D_DIR, 0, 8'hFF);
        acc(gpio_de_pkg::ADDR_PORT_D_DIR, 1, 8'h00);
        chk({4'h0, pu, slow}, 8'h0F);
        acc(gpio_de_pkg::ADDR_PORT_D_CTRL, 1, 8'h00);
        acc(gpio_de_pkg::ADDR_PORT_E_DATA, 1, 8'hFD);
        acc(gpio_de_pkg::ADDR_PORT_E_DATA, 0, 8'h02);
        acc(gpio_de_pkg::ADDR_PORT_E_DIR, 1, 8'hFF);
        acc(gpio_de_pkg::ADDR_PORT_E_DIR, 0, 8'h03);
        acc(gpio_de_pkg::ADDR_PORT_E_DATA, 0, 8'h01);
        chk({6'h00, pe_oe}, 8'h03);
        {ser_en, ser_tx, t1s, t1e, t1o, t2s, t2e} = {1'b1, 1'b1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};
        @(posedge clk);
        #1;
        chk({pd_oe[7:6], pd_out[6], ser_rx, pd_oe[4], pd_out[4], pe_oe[0], pe_out[0]}, 8'h7E);
        chk({2'h0, pd_out[5], pe_oe[1], t1i, t2i}, 8'h0E);
        {ser_en, i2c_on, sda_oe} = 3'h3;
        @(posedge clk);
        #1;
        chk({4'h0, sda_in, scl_in, pd_oe[6], pd_out[6]}, 8'h06);
        // Analogue use needs every takeover off and the pins left as inputs.
        {i2c_on, sda_oe, t1s, t1e, t1o, t2s, t2e} = '0;
        acc(16'h0001, 0, 8'h00);
        summarize();
    end
endmodule
